// >>> rtl/iicirq_map.vh
// Purpose: Offsets, field positions and timing counts for the input
//          change interrupt block.
// Assumes: 16-bit registers at byte offsets on the local bus.
// Notes:   Definitions only.
`ifndef IICIRQ_MAP_VH
`define IICIRQ_MAP_VH

`define IICIRQ_OFS_INPUT_LEVEL   4'h4
`define IICIRQ_OFS_EDGE          4'h6
`define IICIRQ_OFS_IRQ           4'h8

`define IICIRQ_BIT_CLR_CHANGE    0
`define IICIRQ_BIT_CLR_INPUT0    1
`define IICIRQ_BIT_CLR_INPUT1    2
`define IICIRQ_BIT_EN_CHANGE     8
`define IICIRQ_BIT_EN_INPUT0     9
`define IICIRQ_BIT_EN_INPUT1     10

`define IICIRQ_RST_WORD          16'h0000
`define IICIRQ_RST_EN            3'h0

// Sampling clock rate in kHz and system clock in kHz
`define IICIRQ_SAMPLE_KHZ        8250
`define IICIRQ_CLOCK_KHZ         200000
// Divider: largest whole count not slower than the sampling rate
`define IICIRQ_SAMPLE_DIV  (`IICIRQ_CLOCK_KHZ / `IICIRQ_SAMPLE_KHZ)
`define IICIRQ_DIV_W             5
// Last divider count, sampling divide minus one, sized to the counter
`define IICIRQ_SAMPLE_LAST       5'h17

`endif

// >>> rtl/iicirq_sampler.v
// Purpose: Sampling-clock enable and two-stage synchroniser with a
//          sample register for the isolated inputs.
// Assumes: Inputs are asynchronous to i_clock.
// Notes:   Sample register updates only on the sampling enable.
`timescale 1ns/10ps
`include "iicirq_map.vh"

module iicirq_sampler (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_srst,
  // Pins
  input  wire [15:0] i_pins,
  // Sampled levels
  output reg  [15:0] o_sample,
  output reg         o_strobe
);

  reg [15:0]                 sync1_ff;
  reg [15:0]                 sync2_ff;
  reg [`IICIRQ_DIV_W-1:0]    div_ff;
  wire                       div_wrap;

  assign div_wrap = (div_ff == `IICIRQ_SAMPLE_LAST);

  always @(posedge i_clock) begin
    sync1_ff <= i_pins;
    sync2_ff <= sync1_ff;
  end

  // Sampling enable at about 8.33 MHz
  always @(posedge i_clock) begin
    if (i_srst) begin
      div_ff   <= {`IICIRQ_DIV_W{1'b0}};
      o_strobe <= 1'b0;
      o_sample <= `IICIRQ_RST_WORD;
    end else begin
      o_strobe <= div_wrap;
      if (div_wrap) begin
        div_ff   <= {`IICIRQ_DIV_W{1'b0}};
        o_sample <= sync2_ff;
      end else begin
        div_ff <= div_ff + 1'b1;
      end
    end
  end

endmodule

// >>> rtl/iicirq_top.v
// Purpose: Isolated input level, change-of-state detection with
//          snapshot, and two-mode interrupt unit.
// Assumes: 16-bit local bus accesses, one-cycle read/write strobes.
// Notes:   One clock; the input sampling rate is an enable pulse.
// Functional notes
// - Input level register returns sampled inputs
// - Write-only per-channel change detect enables
// - Any edge on enabled channel requests
// - Change request captures all inputs snapshot
// - Snapshot clears when change request cleared
// - Mode two: channels 0,1 rising only
// - Write one clears request; zero ignored
// - Request held until software clears it
// - Control bits 8..10 are source enables
// - Enable pattern selects interrupt setup
// - Status bits 0..2 show pending requests
// - Status bits 8..10 show enables
// - All registers sixteen bits, 16-bit access
// - Inputs sampled every 24 clocks, about 8.33 MHz
`timescale 1ns/10ps
`include "iicirq_map.vh"

module iicirq_top (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_srst,
  // Isolated input pins
  input  wire [15:0] i_isolated_input_level,
  // Local bus
  input  wire [3:0]  i_addr,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire [15:0] i_wdata,
  output reg  [15:0] o_rdata,
  output reg         o_rvalid,
  // Interrupt line
  output reg         o_irq
);

  wire [15:0] sample;
  wire        strobe;
  reg  [15:0] prev_ff;
  reg  [15:0] edge_detect_enable_ff;
  reg  [15:0] edge_snapshot_ff;
  reg         input0_source_enable_ff;
  reg         input1_source_enable_ff;
  reg         change_source_enable_ff;
  reg         change_pending_ff;
  reg         input0_request_pending_ff;
  reg         input1_request_pending_ff;
  reg         nxt_change;
  reg         nxt_in0;
  reg         nxt_in1;
  reg  [15:0] nxt_rdata;
  reg  [15:0] status_word;
  reg  [2:0]  mode_sel;
  reg         nxt_irq;
  reg         wr_edge;
  reg         wr_irq;
  wire        clear_change_request;
  wire        clear_input0_request;
  wire        clear_input1_request;
  wire        mode_change;
  wire        mode_input;
  wire [15:0] chan_changed;
  wire [15:0] chan_rose;
  wire        change_event;
  wire        rise0;
  wire        rise1;
  genvar      ch;

  // One-hot interrupt setups decoded from the three source enables
  localparam [2:0] MODE_OFF    = 3'h1;
  localparam [2:0] MODE_CHANGE = 3'h2;
  localparam [2:0] MODE_INPUT  = 3'h4;

  iicirq_sampler u_sampler (
    .i_clock  (i_clock),
    .i_srst   (i_srst),
    .i_pins   (i_isolated_input_level),
    .o_sample (sample),
    .o_strobe (strobe)
  );

  // Full 16-bit words only; no byte lanes
  always @* begin
    wr_edge = 1'b0;
    wr_irq  = 1'b0;
    if (i_wr) begin
      case (i_addr)
        `IICIRQ_OFS_EDGE: begin
          wr_edge = 1'b1;
        end
        `IICIRQ_OFS_IRQ: begin
          wr_irq = 1'b1;
        end
        default: begin
          // Level register and unmapped offsets ignore writes
          wr_edge = 1'b0;
        end
      endcase
    end
  end

  assign clear_change_request =
    wr_irq && i_wdata[`IICIRQ_BIT_CLR_CHANGE];
  assign clear_input0_request =
    wr_irq && i_wdata[`IICIRQ_BIT_CLR_INPUT0];
  assign clear_input1_request =
    wr_irq && i_wdata[`IICIRQ_BIT_CLR_INPUT1];

  // Mixed setups fall back to disabled, guarding against misuse
  always @* begin
    mode_sel = MODE_OFF;
    case ({input1_source_enable_ff, input0_source_enable_ff,
           change_source_enable_ff})
      3'h1: begin
        mode_sel = MODE_CHANGE;
      end
      3'h2, 3'h4, 3'h6: begin
        mode_sel = MODE_INPUT;
      end
      default: begin
        mode_sel = MODE_OFF;
      end
    endcase
  end

  assign mode_change = mode_sel[1];
  assign mode_input  = mode_sel[2];

  // Edges are judged between consecutive samples only; a pulse that
  // starts and ends between two strobes is never seen
  generate
    for (ch = 0; ch < 16; ch = ch + 1) begin : g_chan
      assign chan_changed[ch] = edge_detect_enable_ff[ch] &&
        (sample[ch] != prev_ff[ch]);
      assign chan_rose[ch] = sample[ch] && !prev_ff[ch];
    end
  endgenerate

  assign change_event = strobe && mode_change &&
    (|chan_changed);
  assign rise0 = strobe && mode_input && input0_source_enable_ff &&
    chan_rose[0];
  assign rise1 = strobe && mode_input && input1_source_enable_ff &&
    chan_rose[1];

  // Set wins over a clear in the same cycle; held until cleared
  always @* begin
    nxt_change = change_pending_ff;
    nxt_in0    = input0_request_pending_ff;
    nxt_in1    = input1_request_pending_ff;
    if (clear_change_request) begin
      nxt_change = 1'b0;
    end
    if (clear_input0_request) begin
      nxt_in0 = 1'b0;
    end
    if (clear_input1_request) begin
      nxt_in1 = 1'b0;
    end
    if (change_event) begin
      nxt_change = 1'b1;
    end
    if (rise0) begin
      nxt_in0 = 1'b1;
    end
    if (rise1) begin
      nxt_in1 = 1'b1;
    end
  end

  // Pending bits of a source disabled later no longer drive the line
  always @* begin
    nxt_irq = 1'b0;
    if (mode_change) begin
      nxt_irq = nxt_change;
    end else if (mode_input) begin
      nxt_irq = (input0_source_enable_ff && nxt_in0) ||
        (input1_source_enable_ff && nxt_in1);
    end
  end

  // Request flags low, source enables high, reserved bits read zero
  always @* begin
    status_word = `IICIRQ_RST_WORD;
    status_word[`IICIRQ_BIT_CLR_CHANGE] = change_pending_ff;
    status_word[`IICIRQ_BIT_CLR_INPUT0] =
      input0_request_pending_ff;
    status_word[`IICIRQ_BIT_CLR_INPUT1] =
      input1_request_pending_ff;
    status_word[`IICIRQ_BIT_EN_CHANGE] =
      change_source_enable_ff;
    status_word[`IICIRQ_BIT_EN_INPUT0] =
      input0_source_enable_ff;
    status_word[`IICIRQ_BIT_EN_INPUT1] =
      input1_source_enable_ff;
  end

  always @(posedge i_clock) begin
    if (i_srst) begin
      prev_ff                   <= `IICIRQ_RST_WORD;
      edge_detect_enable_ff     <= `IICIRQ_RST_WORD;
      edge_snapshot_ff          <= `IICIRQ_RST_WORD;
      change_source_enable_ff   <= 1'b0;
      input0_source_enable_ff   <= 1'b0;
      input1_source_enable_ff   <= 1'b0;
      change_pending_ff         <= 1'b0;
      input0_request_pending_ff <= 1'b0;
      input1_request_pending_ff <= 1'b0;
    end else begin
      if (strobe) begin
        prev_ff <= sample;
      end
      if (wr_edge) begin
        edge_detect_enable_ff <= i_wdata;
      end
      if (wr_irq) begin
        change_source_enable_ff <=
          i_wdata[`IICIRQ_BIT_EN_CHANGE];
        input0_source_enable_ff <=
          i_wdata[`IICIRQ_BIT_EN_INPUT0];
        input1_source_enable_ff <=
          i_wdata[`IICIRQ_BIT_EN_INPUT1];
      end
      // A fresh capture beats the clear, matching the request flag
      if (change_event) begin
        edge_snapshot_ff <= sample;
      end else if (clear_change_request) begin
        edge_snapshot_ff <= `IICIRQ_RST_WORD;
      end
      change_pending_ff         <= nxt_change;
      input0_request_pending_ff <= nxt_in0;
      input1_request_pending_ff <= nxt_in1;
    end
  end

  always @* begin
    nxt_rdata = `IICIRQ_RST_WORD;
    case (i_addr)
      `IICIRQ_OFS_INPUT_LEVEL: begin
        nxt_rdata = sample;
      end
      `IICIRQ_OFS_EDGE: begin
        nxt_rdata = edge_snapshot_ff;
      end
      `IICIRQ_OFS_IRQ: begin
        nxt_rdata = status_word;
      end
      default: begin
        nxt_rdata = `IICIRQ_RST_WORD;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (i_srst) begin
      o_rdata  <= `IICIRQ_RST_WORD;
      o_rvalid <= 1'b0;
      o_irq    <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        o_rdata <= nxt_rdata;
      end
      // Uses next flags so a set or clear shows on the line at once
      o_irq <= nxt_irq;
    end
  end

endmodule

// >>> tb/iicirq_props.sv
// Purpose: Port checks for the input change interrupt block.
// Assumes: Read and write strobes never together.
// Notes:   en_ff mirrors the enables last written.
`timescale 1ns/10ps
module iicirq_props (
  // Clock, reset, pins
  input wire        i_clock,
  input wire        i_srst,
  input wire [15:0] i_isolated_input_level,
  // Bus and line
  input wire [3:0]  i_addr,
  input wire        i_wr,
  input wire        i_rd,
  input wire [15:0] i_wdata,
  input wire [15:0] o_rdata,
  input wire        o_rvalid,
  input wire        o_irq
);
  reg  [2:0] en_ff;
  wire       wr_ctl = i_wr && i_addr == 4'h8;
  wire       rd_ctl = i_rd && i_addr == 4'h8;
  wire       en_ok  = en_ff == 3'h1 || en_ff == 3'h2 ||
                      en_ff == 3'h4 || en_ff == 3'h6;
  always @(posedge i_clock)
    if (i_srst)
      en_ff <= 3'h0;
    else if (wr_ctl)
      en_ff <= i_wdata[10:8];
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  property p_rv; i_rd |=> o_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_idle; !i_rd |=> !o_rvalid && $stable(o_rdata); endproperty
  a_idle: assert property (p_idle) else $error("idle read");
  property p_rsv; rd_ctl |=> o_rdata[15:11] == 5'h0 && o_rdata[7:3] == 5'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_en; rd_ctl |=> o_rdata[10:8] == en_ff; endproperty
  a_en: assert property (p_en) else $error("enable echo");
  // A setup write moves the line one cycle after the write itself
  property p_hold; o_irq && !wr_ctl && !$past(wr_ctl) |=> o_irq;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_bad; wr_ctl && i_wdata[8] && |i_wdata[10:9] |=> ##1 !o_irq;
  endproperty
  a_bad: assert property (p_bad) else $error("forbidden irq");
  property p_off; wr_ctl && i_wdata[10:8] == 3'h0 |=> ##1 !o_irq;
  endproperty
  a_off: assert property (p_off) else $error("disabled irq");
  property p_mode; o_irq && !$past(wr_ctl) |-> en_ok; endproperty
  a_mode: assert property (p_mode) else $error("irq mode");
endmodule
bind iicirq_top iicirq_props u_props (.i_clock(i_clock), .i_srst(i_srst),
  .i_isolated_input_level(i_isolated_input_level), .i_addr(i_addr),
  .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .o_irq(o_irq));

// >>> tb/iicirq_host.sv
// Purpose: Bridge side strobe bus master.
// Assumes: One-cycle strobes, answer one cycle later.
// Notes:   Released lines show the inverse of the last value.
`timescale 1ns/10ps
module iicirq_host (
  // Clock and answer
  input  wire        i_clock,
  input  wire [15:0] i_rdata,
  input  wire        i_rvalid,
  // Strobe bus
  output reg  [3:0]  o_addr,
  output reg         o_wr,
  output reg         o_rd,
  output reg  [15:0] o_wdata
);
  initial begin
    o_addr = 4'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge i_clock) #1;
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_clock) #1;
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
    end
  endtask
  task rd(input [3:0] a, output [15:0] d);
    begin
      @(posedge i_clock) #1;
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_clock) #1;
      // Answer stands through the whole cycle after the strobe edge
      d = (i_rvalid === 1'b1) ? i_rdata : 16'hxxxx;
      o_rd = 1'b0;
      o_addr = ~a;
    end
  endtask
endmodule

// >>> tb/isolated_input_change_irq_test.sv
// Purpose: Scenario bench for the input change interrupt block.
// Assumes: Pin to line latency below 30 cycles.
// Notes:   Checks only, no random stimulus.
`timescale 1ns/10ps
`include "iicirq_map.vh"
module isolated_input_change_irq_test;
  reg         clock;
  reg         srst;
  reg  [15:0] pins;
  reg  [15:0] d;
  wire [3:0]  addr;
  wire        wr;
  wire        rd;
  wire        rvalid;
  wire        irq;
  wire [15:0] wdata;
  wire [15:0] rdata;
  integer     fail_count = 0;
  integer     n_tests = 0;
  iicirq_top dut (.i_clock(clock), .i_srst(srst),
    .i_isolated_input_level(pins), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .o_irq(irq));
  iicirq_host host (.i_clock(clock), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: %h %h", $time, got, exp);
      end
    end
  endtask
  // Enough cycles for sync, sample strobe and request
  task pins_to(input [15:0] v);
    begin
      @(posedge clock) #1;
      pins = v;
      repeat (30) @(posedge clock);
    end
  endtask
  task t_level;
    begin
      pins_to(16'hA5C3);
      host.wr(`IICIRQ_OFS_INPUT_LEVEL, 16'h0000);
      host.rd(`IICIRQ_OFS_INPUT_LEVEL, d);
      chk(d, 16'hA5C3);
      host.rd(4'hA, d);
      chk(d, 16'h0000);
    end
  endtask
  task t_change;
    begin
      host.wr(`IICIRQ_OFS_EDGE, 16'h0002);
      host.wr(`IICIRQ_OFS_IRQ, 16'h0100);
      pins_to(16'hA5C7);
      chk({15'h0, irq}, 16'h0000);
      pins_to(16'hA5C5);
      chk({15'h0, irq}, 16'h0001);
      host.rd(`IICIRQ_OFS_EDGE, d);
      chk(d, 16'hA5C5);
      host.wr(`IICIRQ_OFS_IRQ, 16'h0100);
      host.rd(`IICIRQ_OFS_IRQ, d);
      chk(d, 16'h0101);
      host.wr(`IICIRQ_OFS_IRQ, 16'h0101);
      host.rd(`IICIRQ_OFS_EDGE, d);
      chk(d, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
    end
  endtask
  task t_rise;
    begin
      host.wr(`IICIRQ_OFS_IRQ, 16'h0600);
      pins_to(16'hA5C4);
      chk({15'h0, irq}, 16'h0000);
      pins_to(16'hA5C5);
      host.rd(`IICIRQ_OFS_IRQ, d);
      chk(d, 16'h0602);
      host.wr(`IICIRQ_OFS_IRQ, 16'h0602);
      host.rd(`IICIRQ_OFS_IRQ, d);
      chk(d, 16'h0600);
      pins_to(16'hA5C7);
      host.rd(`IICIRQ_OFS_IRQ, d);
      chk(d, 16'h0604);
      chk({15'h0, irq}, 16'h0001);
      host.wr(`IICIRQ_OFS_IRQ, 16'h0604);
      chk({15'h0, irq}, 16'h0000);
      host.wr(`IICIRQ_OFS_IRQ, 16'h0200);
      pins_to(16'hA5C5);
      pins_to(16'hA5C7);
      chk({15'h0, irq}, 16'h0000);
      host.wr(`IICIRQ_OFS_IRQ, 16'h0700);
      pins_to(16'hA5C4);
      pins_to(16'hA5C5);
      chk({15'h0, irq}, 16'h0000);
      host.wr(`IICIRQ_OFS_IRQ, 16'h0000);
    end
  endtask
  task t_reset;
    begin
      host.wr(`IICIRQ_OFS_EDGE, 16'hFFFF);
      host.wr(`IICIRQ_OFS_IRQ, 16'h0100);
      pins_to(16'h5A3A);
      chk({15'h0, irq}, 16'h0001);
      host.rd(`IICIRQ_OFS_EDGE, d);
      chk(d, 16'h5A3A);
      @(posedge clock) #1;
      srst = 1'b1;
      repeat (2) @(posedge clock);
      #1 srst = 1'b0;
      chk({15'h0, irq}, 16'h0000);
      host.rd(`IICIRQ_OFS_IRQ, d);
      chk(d, 16'h0000);
      host.rd(`IICIRQ_OFS_EDGE, d);
      chk(d, 16'h0000);
    end
  endtask
  task test_done;
    begin
      if (fail_count == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    srst = 1'b1;
    pins = 16'h0000;
    repeat (20) @(posedge clock);
    #1 srst = 1'b0;
    t_level;
    t_change;
    t_rise;
    t_reset;
    repeat (4) @(posedge clock);
    test_done;
  end
  initial begin
    #20000;
    fail_count = fail_count + 1;
    test_done;
  end
endmodule
